//--- ceid_pkg.sv
package ceid_pkg;

  // ------------------------------------------------------------
  // Instruction word fields
  // ------------------------------------------------------------
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int RN_LO = 16;
  localparam int RD_LO = 12;
  localparam int RM_LO = 0;
  localparam int OPC_LO = 21;
  localparam int SBIT_POS = 20;
  localparam int LINK_POS = 24;
  localparam int MUL_BIT6_POS = 6;
  localparam int PSR_SEL_POS = 22;
  localparam logic [3:0] LINK_REG = 4'hE;
  localparam logic [3:0] PC_REG = 4'hF;
  localparam logic [31:0] PC_AHEAD = 32'h0000_0008;
  localparam logic [31:0] RET_ADJ = 32'h0000_0004;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;

  // ------------------------------------------------------------
  // Condition codes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CEID_EQ = 4'h0, CEID_NE = 4'h1, CEID_CS = 4'h2, CEID_CC = 4'h3,
    CEID_MI = 4'h4, CEID_PL = 4'h5, CEID_VS = 4'h6, CEID_VC = 4'h7,
    CEID_HI = 4'h8, CEID_LS = 4'h9, CEID_GE = 4'hA, CEID_LT = 4'hB,
    CEID_GT = 4'hC, CEID_LE = 4'hD, CEID_AL = 4'hE, CEID_NV = 4'hF
  } ceid_cond_t;

  // ------------------------------------------------------------
  // Data processing opcodes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CEID_AND = 4'h0, CEID_XOR = 4'h1, CEID_SUB = 4'h2, CEID_RSB = 4'h3,
    CEID_ADD = 4'h4, CEID_ADC = 4'h5, CEID_SBC = 4'h6, CEID_RSC = 4'h7,
    CEID_TST = 4'h8, CEID_TEQ = 4'h9, CEID_CMP = 4'hA, CEID_CMN = 4'hB,
    CEID_ORR = 4'hC, CEID_MOV = 4'hD, CEID_BCLR = 4'hE, CEID_MVN = 4'hF
  } ceid_alu_op_t;

  // ------------------------------------------------------------
  // Format classes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CEID_F_DATA = 4'h0, CEID_F_MUL = 4'h1, CEID_F_MULL = 4'h2,
    CEID_F_SWAP = 4'h3, CEID_F_BXCH = 4'h4, CEID_F_HALF = 4'h5,
    CEID_F_SINGLE = 4'h6, CEID_F_UNDEF = 4'h7, CEID_F_BLOCK = 4'h8,
    CEID_F_BRANCH = 4'h9, CEID_F_COPRO = 4'hA, CEID_F_SWI = 4'hB
  } ceid_fmt_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } ceid_flags_t;

  // Operands delivered by the register file read stage
  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] first;
    logic [31:0] second;
    logic [31:0] store;
    logic shift_carry;
  } ceid_ops_t;

  // Decoded effect handed to execute
  typedef struct packed {
    logic valid;
    ceid_fmt_t fmt;
    logic exec;
    logic undef_trap;
    logic rd_we;
    logic [3:0] rd;
    logic [31:0] result;
    logic flags_we;
    ceid_flags_t flags;
    logic link_we;
    logic [31:0] link_val;
    logic pc_we;
    logic [31:0] pc_val;
    logic state_we;
    logic state_bit;
    logic mem_swap;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic psr_we;
    logic psr_flags_only;
    logic psr_saved;
    logic [31:0] psr_val;
  } ceid_dec_t;

endpackage

//--- ceid_decoder.sv
module ceid_decoder (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire ceid_pkg::ceid_flags_t current_status_register,
  input wire logic [31:0] saved_status,
  input wire ceid_pkg::ceid_ops_t ops,
  output ceid_pkg::ceid_dec_t dec
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic cond_pass(input logic [3:0] cc, input ceid_pkg::ceid_flags_t f);
    logic p;
    p = 1'b0;
    case (cc)
      ceid_pkg::CEID_EQ: p = f.z;
      ceid_pkg::CEID_NE: p = !f.z;
      ceid_pkg::CEID_CS: p = f.c;
      ceid_pkg::CEID_CC: p = !f.c;
      ceid_pkg::CEID_MI: p = f.n;
      ceid_pkg::CEID_PL: p = !f.n;
      ceid_pkg::CEID_VS: p = f.v;
      ceid_pkg::CEID_VC: p = !f.v;
      ceid_pkg::CEID_HI: p = f.c && !f.z;
      ceid_pkg::CEID_LS: p = !f.c || f.z;
      ceid_pkg::CEID_GE: p = (f.n == f.v);
      ceid_pkg::CEID_LT: p = (f.n != f.v);
      ceid_pkg::CEID_GT: p = !f.z && (f.n == f.v);
      ceid_pkg::CEID_LE: p = f.z || (f.n != f.v);
      ceid_pkg::CEID_AL: p = 1'b1;
      // Reserved code: never executes, so no stray side effects
      default: p = 1'b0;
    endcase
    return p;
  endfunction

  function automatic ceid_pkg::ceid_fmt_t classify(input logic [31:0] w);
    ceid_pkg::ceid_fmt_t f;
    f = ceid_pkg::CEID_F_DATA;
    case (w[27:25])
      3'b000: begin
        if (w[7:4] == 4'h9) begin
          if (w[27:23] == 5'b00000) begin
            f = ceid_pkg::CEID_F_MUL;
          end else if (w[27:23] == 5'b00001) begin
            f = ceid_pkg::CEID_F_MULL;
          end else if (w[27:23] == 5'b00010 && w[21:20] == 2'b00) begin
            f = ceid_pkg::CEID_F_SWAP;
          end else begin
            f = ceid_pkg::CEID_F_DATA;
          end
        end else if (w[27:4] == 24'h12FFF1) begin
          f = ceid_pkg::CEID_F_BXCH;
        end else if (w[7] && w[4]) begin
          f = ceid_pkg::CEID_F_HALF;
        end else begin
          f = ceid_pkg::CEID_F_DATA;
        end
      end
      3'b001: f = ceid_pkg::CEID_F_DATA;
      3'b010: f = ceid_pkg::CEID_F_SINGLE;
      3'b011: f = w[4] ? ceid_pkg::CEID_F_UNDEF : ceid_pkg::CEID_F_SINGLE;
      3'b100: f = ceid_pkg::CEID_F_BLOCK;
      3'b101: f = ceid_pkg::CEID_F_BRANCH;
      3'b110: f = ceid_pkg::CEID_F_COPRO;
      3'b111: f = w[24] ? ceid_pkg::CEID_F_SWI : ceid_pkg::CEID_F_COPRO;
      default: f = ceid_pkg::CEID_F_DATA;
    endcase
    return f;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    ceid_pkg::ceid_dec_t out;
  } ceid_state_t;

  ceid_state_t st_q;
  ceid_state_t st_d;

  logic [3:0] cond;
  logic pass;
  ceid_pkg::ceid_fmt_t fmt;
  ceid_pkg::ceid_alu_op_t opc;
  logic [32:0] sum;
  logic [31:0] logic_res;
  logic [31:0] a;
  logic [31:0] b;
  logic cin;
  logic is_arith;
  logic writes_rd;
  logic psr_to_reg;
  logic reg_to_psr;

  assign cond = instr[ceid_pkg::COND_HI:ceid_pkg::COND_LO];
  assign pass = cond_pass(cond, current_status_register);
  assign fmt = classify(instr);
  assign opc = ceid_pkg::ceid_alu_op_t'(instr[ceid_pkg::OPC_LO +: 4]);
  assign a = ops.first;
  assign b = ops.second;
  // Status moves sit in the test/compare slots with the flag-update bit clear
  assign psr_to_reg = (fmt == ceid_pkg::CEID_F_DATA) && !instr[ceid_pkg::SBIT_POS]
    && (instr[24:23] == 2'b10) && !instr[21] && !instr[25];
  assign reg_to_psr = (fmt == ceid_pkg::CEID_F_DATA) && !instr[ceid_pkg::SBIT_POS]
    && (instr[24:23] == 2'b10) && instr[21];

  // ------------------------------------------------------------
  // Arithmetic and logic
  // ------------------------------------------------------------
  always_comb begin
    sum = 33'h0_0000_0000;
    logic_res = 32'h0000_0000;
    is_arith = 1'b0;
    cin = current_status_register.c;
    case (opc)
      ceid_pkg::CEID_AND, ceid_pkg::CEID_TST: logic_res = a & b;
      ceid_pkg::CEID_XOR, ceid_pkg::CEID_TEQ: logic_res = a ^ b;
      ceid_pkg::CEID_ORR: logic_res = a | b;
      ceid_pkg::CEID_MOV: logic_res = b;
      ceid_pkg::CEID_BCLR: logic_res = a & ~b;
      ceid_pkg::CEID_MVN: logic_res = ~b;
      ceid_pkg::CEID_SUB, ceid_pkg::CEID_CMP: begin
        is_arith = 1'b1;
        sum = {1'b0, a} + {1'b0, ~b} + 33'h0_0000_0001;
      end
      ceid_pkg::CEID_RSB: begin
        is_arith = 1'b1;
        sum = {1'b0, b} + {1'b0, ~a} + 33'h0_0000_0001;
      end
      ceid_pkg::CEID_ADD, ceid_pkg::CEID_CMN: begin
        is_arith = 1'b1;
        sum = {1'b0, a} + {1'b0, b};
      end
      ceid_pkg::CEID_ADC: begin
        is_arith = 1'b1;
        sum = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
      end
      ceid_pkg::CEID_SBC: begin
        is_arith = 1'b1;
        // a - b - 1 + c equals a + ~b + c
        sum = {1'b0, a} + {1'b0, ~b} + {32'h0000_0000, cin};
      end
      ceid_pkg::CEID_RSC: begin
        is_arith = 1'b1;
        sum = {1'b0, b} + {1'b0, ~a} + {32'h0000_0000, cin};
      end
      default: logic_res = 32'h0000_0000;
    endcase
  end

  // Tests and compares never write a destination
  assign writes_rd = !(opc inside {ceid_pkg::CEID_TST, ceid_pkg::CEID_TEQ,
    ceid_pkg::CEID_CMP, ceid_pkg::CEID_CMN});

  // ------------------------------------------------------------
  // Next decoded effect
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] res;
    logic [31:0] s1;
    logic [31:0] s2;
    res = is_arith ? sum[31:0] : logic_res;
    s1 = is_arith ? a : 32'h0000_0000;
    s2 = (opc inside {ceid_pkg::CEID_SUB, ceid_pkg::CEID_CMP, ceid_pkg::CEID_SBC,
      ceid_pkg::CEID_RSB, ceid_pkg::CEID_RSC}) ? ~b : b;
    st_d = st_q;
    st_d.out = '0;
    st_d.out.valid = instr_valid;
    st_d.out.fmt = fmt;
    st_d.out.exec = instr_valid && pass;
    st_d.out.rd = instr[ceid_pkg::RD_LO +: 4];
    st_d.out.flags = current_status_register;
    if (instr_valid && pass) begin
      case (fmt)
        ceid_pkg::CEID_F_DATA: begin
          if (psr_to_reg) begin
            st_d.out.rd_we = 1'b1;
            st_d.out.result = instr[ceid_pkg::PSR_SEL_POS] ? saved_status
              : {current_status_register, 28'h000_0000};
          end else if (reg_to_psr) begin
            st_d.out.psr_we = 1'b1;
            st_d.out.psr_saved = instr[ceid_pkg::PSR_SEL_POS];
            st_d.out.psr_flags_only = !instr[16];
            st_d.out.psr_val = ops.second;
          end else begin
            st_d.out.result = res;
            st_d.out.rd_we = writes_rd;
            st_d.out.flags_we = instr[ceid_pkg::SBIT_POS];
            st_d.out.flags.n = res[31];
            st_d.out.flags.z = (res == 32'h0000_0000);
            if (is_arith) begin
              // Operand order swapped for reverse forms, so RSB and RSC take overflow from b and ~a
              st_d.out.flags.c = sum[32];
              st_d.out.flags.v = (opc inside {ceid_pkg::CEID_RSB, ceid_pkg::CEID_RSC})
                ? (b[31] == ~a[31]) && (res[31] != b[31])
                : (s1[31] == s2[31]) && (res[31] != s1[31]);
            end else begin
              st_d.out.flags.c = ops.shift_carry;
            end
          end
        end
        ceid_pkg::CEID_F_BXCH: begin
          st_d.out.pc_we = 1'b1;
          st_d.out.pc_val = {ops.first[31:1], 1'b0};
          st_d.out.state_we = 1'b1;
          st_d.out.state_bit = ops.first[0];
        end
        ceid_pkg::CEID_F_BRANCH: begin
          st_d.out.pc_we = 1'b1;
          st_d.out.pc_val = ops.pc + PC_AHEAD_OFS(instr[23:0]);
          if (instr[ceid_pkg::LINK_POS]) begin
            st_d.out.link_we = 1'b1;
            st_d.out.rd = ceid_pkg::LINK_REG;
            st_d.out.link_val = {ops.pc[31:2] + 30'h0000_0001, 2'b00};
          end
        end
        ceid_pkg::CEID_F_SWAP: begin
          st_d.out.mem_swap = 1'b1;
          st_d.out.mem_addr = ops.first;
          st_d.out.mem_wdata = ops.store;
          st_d.out.rd_we = 1'b1;
        end
        ceid_pkg::CEID_F_UNDEF: st_d.out.undef_trap = 1'b1;
        // Multiply pattern with bit 6 set classifies as halfword transfer, which has no effect here, no trap
        default: st_d.out.undef_trap = 1'b0;
      endcase
    end
  end

  function automatic logic [31:0] PC_AHEAD_OFS(input logic [23:0] off);
    return ceid_pkg::PC_AHEAD + {{6{off[23]}}, off, 2'b00};
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dec = st_q.out;

endmodule

//--- ceid_decoder_checker.sv
module ceid_decoder_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire ceid_pkg::ceid_flags_t current_status_register,
  input wire logic [31:0] saved_status,
  input wire ceid_pkg::ceid_ops_t ops,
  input wire ceid_pkg::ceid_dec_t dec
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic al = instr_valid && instr[31:28] == 4'hE;
  wire logic dp_test = instr[27:26] == 2'b00 && instr[24:23] == 2'b10 && instr[20]
    && (instr[25] || !(instr[7] && instr[4]));
  wire ceid_pkg::ceid_flags_t f = current_status_register;
  a_idle_no_result: assert property (!instr_valid |=> !dec.valid)
    else $error("result without request");
  a_always_runs: assert property (al |=> dec.exec)
    else $error("always code did not execute");
  a_zero_set: assert property (instr_valid && instr[31:28] == 4'h0 |=> dec.exec == $past(f.z))
    else $error("zero-set code wrong");
  a_unsigned_hi: assert property (instr_valid && instr[31:28] == 4'h8
    |=> dec.exec == $past(f.c && !f.z)) else $error("unsigned higher code wrong");
  a_signed_le: assert property (instr_valid && instr[31:28] == 4'hD
    |=> dec.exec == $past(f.z || f.n != f.v)) else $error("signed le code wrong");
  a_fail_quiet: assert property (dec.valid && !dec.exec |-> !(dec.rd_we || dec.flags_we
    || dec.pc_we || dec.link_we || dec.psr_we || dec.mem_swap || dec.state_we || dec.undef_trap))
    else $error("failed condition left an effect");
  a_test_no_rd: assert property (al && dp_test |=> !dec.rd_we && dec.flags_we)
    else $error("test op wrote a register");
  a_bx_target: assert property (al && instr[27:4] == 24'h12FFF1
    |=> dec.pc_val == {$past(ops.first[31:1]), 1'b0} && dec.state_bit == $past(ops.first[0]))
    else $error("exchange branch target or state wrong");
  a_undef_pass: assert property (instr_valid && instr[27:25] == 3'b011 && instr[4]
    |=> dec.undef_trap == dec.exec) else $error("undefined flag wrong");
  a_link_write: assert property (al && instr[27:24] == 4'hB
    |=> dec.link_we && dec.link_val == $past(ops.pc) + 32'h0000_0004)
    else $error("link value wrong");
  c_refused: cover property (dec.valid && !dec.exec);
  c_undef: cover property (dec.undef_trap);
  c_state: cover property (dec.state_we && dec.state_bit);
endmodule

bind ceid_decoder ceid_decoder_checker i_chk (.mclk(mclk), .rst_n(rst_n),
  .instr_valid(instr_valid), .instr(instr), .current_status_register(current_status_register),
  .saved_status(saved_status), .ops(ops), .dec(dec));

//--- ceid_decoder_tb.sv
module ceid_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0;
  logic rst_n = 0;
  logic instr_valid = 0;
  logic [31:0] instr = '0;
  logic [31:0] saved_status = '0;
  ceid_pkg::ceid_flags_t current_status_register = '0;
  ceid_pkg::ceid_ops_t ops = '0;
  ceid_pkg::ceid_dec_t dec, e, m;
  ceid_pkg::ceid_dec_t qe[$], qm[$];
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] a, b, r, pcv;
  logic [31:0] res [16];
  ceid_pkg::ceid_flags_t f;
  logic p;
  always #50 mclk = ~mclk;
  ceid_decoder i_ceid_decoder (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .current_status_register(current_status_register),
    .saved_status(saved_status), .ops(ops), .dec(dec));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic pass(input logic [3:0] c, input ceid_pkg::ceid_flags_t x);
    logic [15:0] t;
    t = {1'b0, 1'b1, x.z | (x.n ^ x.v), !x.z & (x.n == x.v), x.n ^ x.v, x.n == x.v,
      !x.c | x.z, x.c & !x.z, !x.v, x.v, !x.n, x.n, !x.c, x.c, !x.z, x.z};
    return t[c];
  endfunction
  task automatic check(input ceid_pkg::ceid_dec_t seen, input ceid_pkg::ceid_dec_t want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    n_errors += qe.size();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Every effect enable is watched, so a stray write is seen too
  task automatic base;
    e = '0;
    m = '0;
    {m.valid, m.exec, m.undef_trap, m.rd_we, m.flags_we, m.link_we, m.pc_we} = '1;
    {m.state_we, m.mem_swap, m.psr_we} = '1;
    e.valid = 1'b1;
    e.exec = p;
  endtask
  task automatic go(input logic [31:0] w);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= w;
    current_status_register <= f;
    saved_status <= r;
    ops <= {pcv, a, b, r, 1'b0};
    qe.push_back(e & m);
    qm.push_back(m);
  endtask
  always @(negedge mclk) if (dec.valid === 1'b1) begin
    if (qm.size() == 0) begin
      n_errors++;
      $display("mismatch at %0t: unexpected result", $time);
    end else check(dec & qm.pop_front(), qe.pop_front());
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    conclude;
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(2728));
    pcv = $urandom & 32'hFFFF_FFFC;
    r = $urandom;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int c = 0; c < 16; c++) for (int k = 0; k < 16; k++) begin
      f = k[3:0];
      p = pass(c[3:0], f);
      a = $urandom;
      b = $urandom;
      base;
      e.rd_we = p;
      e.rd = 4'h3;
      e.result = a + b;
      if (p) {m.rd, m.result} = '1;
      go({c[3:0], 28'h0813002});
    end
    p = 1'b1;
    for (int o = 0; o < 16; o++) begin
      f = $urandom;
      a = $urandom;
      b = $urandom;
      res = '{a & b, a ^ b, a - b, b - a, a + b, a + b + f.c, a - b - 1 + f.c, b - a - 1 + f.c,
        a & b, a ^ b, a - b, a + b, a | b, b, a & ~b, ~b};
      base;
      e.flags_we = o[3:2] == 2'b10;
      e.rd_we = !e.flags_we;
      e.rd = 4'h3;
      e.result = res[o];
      if (e.rd_we) {m.rd, m.result} = '1;
      go({4'hE, 3'b000, o[3:0], e.flags_we, 20'h13002});
    end
    for (int l = 0; l < 2; l++) begin
      b = $urandom;
      base;
      e.pc_we = 1'b1;
      e.pc_val = pcv + 32'h8 + {{6{b[23]}}, b[23:0], 2'b00};
      e.link_we = l[0];
      e.link_val = pcv + 32'h4;
      m.pc_val = '1;
      m.link_val = {32{l[0]}};
      go({4'hE, 3'b101, l[0], b[23:0]});
      a = $urandom;
      a[0] = l[0];
      base;
      {e.pc_we, e.state_we} = 2'b11;
      e.pc_val = {a[31:1], 1'b0};
      e.state_bit = a[0];
      {m.pc_val, m.state_bit} = '1;
      go(32'hE12FFF11);
    end
    base;
    e.mem_swap = 1'b1;
    e.mem_addr = a;
    e.mem_wdata = r;
    e.rd_we = 1'b1;
    e.rd = 4'h3;
    {m.mem_addr, m.mem_wdata} = '1;
    go(32'hE1013092);
    for (int s = 0; s < 2; s++) begin
      base;
      e.rd_we = 1'b1;
      e.rd = 4'h3;
      e.result = s ? r : {f, 28'h0};
      {m.rd, m.result} = '1;
      go({8'hE1, 1'b0, s[0], 22'h0F_3000});
    end
    base;
    {e.psr_we, e.psr_flags_only} = 2'b11;
    m.psr_flags_only = 1'b1;
    go(32'hE128F002);
    base;
    go(32'hE00302D1);
    f = 4'h0;
    for (int u = 0; u < 2; u++) begin
      p = u[0];
      base;
      e.undef_trap = p;
      go({u[0] ? 4'hE : 4'h0, 28'h6000010});
    end
    @(posedge mclk);
    instr_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    conclude;
  end
endmodule
